// *** hw/receive_fifo_status.v ***
`timescale 1ns/1ps
`include "rx_fifo_consts.vh"
module receive_fifo_status #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // aw/w latches
  reg        awHeld;
  reg [7:0]  awAddr;
  reg        wHeld;
  reg [31:0] wData;
  reg [3:0]  wStrb;
  // control register: trigger enable, flush bad, tx fifo sizes
  reg [31:0] ctrl;
  // token queued by an open-block write, pushed ahead of its data
  reg [8:0]  pendCount;
  reg        pendLast;
  reg        pendValid;
  // status register
  reg [31:0] status;
  // fifo wiring
  wire [32:0] fifoIn;
  wire        fifoInValid;
  wire        fifoInReady;
  wire [32:0] fifoOut;
  wire        fifoOutValid;
  wire        fifoPop;
  wire [AW:0] level;
  wire        wrGo;
  wire        rdGo;
  wire [9:0]  capacity;
  wire        singleBlock;

  // byte-lane merge of a written word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  assign wrGo = awHeld & wHeld & ~s_axi_bvalid;
  assign rdGo = s_axi_arvalid & s_axi_arready;
  assign singleBlock = ~ctrl[`CTRL_TRIG_EN] | ctrl[`CTRL_FLUSH_BAD];
  assign capacity = `SHARED_RAM_QUADS - {1'b0, ctrl[`CTRL_ATF_LO +: 9]}
                    - {1'b0, ctrl[`CTRL_ITF_LO +: 9]};
  // load port: each write pushes one data quadlet, held off while a token waits
  assign fifoIn      = {`TAG_DATA, wData};
  assign fifoInValid = wrGo & (awAddr == `OFF_RX_LOAD) & ~pendValid;
  // data port read pops the head quadlet
  assign fifoPop = rdGo & (s_axi_araddr == `OFF_RX_DATA) & fifoOutValid;

  rx_fifo_buf #(.WIDTH(33), .DEPTH(DEPTH), .AW(AW)) u_buf (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .inData   (pendValid ? {`TAG_TOKEN, 8'h00, pendLast, 14'h0000, pendCount}
                         : fifoIn),
    .inValid  (pendValid | fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .level    (level)
  );

  // write channel, control and block-token generation
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      awAddr        <= 8'h00;
      wHeld         <= 1'b0;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      ctrl          <= 32'h00000000;
      pendCount     <= 9'h000;
      pendLast      <= 1'b0;
      pendValid     <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (pendValid && fifoInReady) begin
        pendValid <= 1'b0;
      end
      // stall a load while the token slot or the fifo is busy, an open only while the token slot is busy
      if (wrGo && !((awAddr == `OFF_RX_LOAD && (pendValid || !fifoInReady)) ||
                    (awAddr == `OFF_RX_OPEN && pendValid))) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (awAddr)
          `OFF_RX_CTRL: begin
            ctrl <= merge(ctrl, wData, wStrb);
          end
          `OFF_RX_STATUS: begin
            s_axi_bresp <= 2'b00;
          end
          `OFF_RX_LOAD: begin
            s_axi_bresp <= 2'b00; // pushed by fifoInValid
          end
          `OFF_RX_OPEN: begin
            // open block: token goes in ahead of its data
            pendCount <= wData[8:0];
            pendLast  <= wData[`TOK_LAST] | singleBlock;
            pendValid <= 1'b1;
          end
          default: begin
            s_axi_bresp <= 2'b10;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel and status image
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
      status        <= `STATUS_RESET;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      // status fields follow the fifo and ctrl every cycle that ce is high
      status[`BIT_EMPTY] <= ~fifoOutValid;
      status[`BIT_TOKEN] <= fifoOutValid & fifoOut[32];
      status[`BIT_LAST]  <= fifoOutValid & fifoOut[32] & fifoOut[`TOK_LAST];
      status[`TOTAL_HI:`TOTAL_LO] <= {{(10-AW-1){1'b0}}, level};
      status[`CAP_HI:`CAP_LO]     <= capacity;
      status[`NEXT_HI:`NEXT_LO]   <= (fifoOutValid & fifoOut[32]) ?
                                     fifoOut[8:0] + 9'h001 : 9'h000;
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `OFF_RX_STATUS: s_axi_rdata <= status;
          `OFF_RX_CTRL:   s_axi_rdata <= ctrl;
          `OFF_RX_DATA:   s_axi_rdata <= fifoOutValid ? fifoOut[31:0] : 32'h00000000;
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// *** hw/rx_fifo_buf.v ***
`timescale 1ns/1ps
// plain valid/ready fifo, tag bit rides above the data
module rx_fifo_buf #(
  parameter WIDTH = 33,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady,
  output reg  [AW:0]      level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  wire            doWr;
  wire            doRd;

  // full and empty come straight from the level
  assign inReady  = (level != DEPTH[AW:0]);
  assign outValid = (level != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];
  assign doWr     = ce & inValid & inReady;
  assign doRd     = ce & outValid & outReady;

  // storage
  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      level <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= rdPtr + 1'b1;
      end
      if (doWr && !doRd) begin
        level <= level + 1'b1;
      end else if (doRd && !doWr) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule

// *** hw/rx_fifo_consts.vh ***
`ifndef RX_FIFO_CONSTS_VH
`define RX_FIFO_CONSTS_VH
// register byte offsets
`define OFF_RX_STATUS     8'h3c
`define OFF_RX_DATA       8'hc0
`define OFF_RX_CTRL       8'h40
`define OFF_RX_LOAD       8'h44
`define OFF_RX_OPEN       8'h48
`define STATUS_RESET      32'h00000000
// status field positions
`define BIT_EMPTY         0
`define BIT_TOKEN         1
`define BIT_LAST          2
`define TOTAL_LO          3
`define TOTAL_HI          12
`define CAP_LO            13
`define CAP_HI            22
`define NEXT_LO           23
`define NEXT_HI           31
// control register fields
`define CTRL_TRIG_EN      0
`define CTRL_FLUSH_BAD    1
`define CTRL_ATF_LO       8
`define CTRL_ITF_LO       20
`define SHARED_RAM_QUADS  10'd512
// load port tags
`define TAG_DATA          1'b0
`define TAG_TOKEN         1'b1
// token word: end-of-packet bit, data count in the low bits
`define TOK_LAST          23
`endif

// *** tb/host_bus_model.sv ***
`timescale 1ns/1ps
// host side of the register bus, one write and one read at a time
module host_bus_model (
  input  wire        clk,
  output reg  [7:0]  s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [7:0]  s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
  end
  // address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] d, output [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // address dropped when taken, rready held until the answer is sampled
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** tb/receive_fifo_status_tb.sv ***
`timescale 1ns/1ps
module receive_fifo_status_tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         ce = 1'b0;
  wire [7:0]  s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0]  s_axi_wstrb;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  integer     n_errors = 0, n_compared = 0, seed = 32'h260c, i;
  integer     q[$];
  reg         tg[$];
  reg         split = 1'b0;
  reg [31:0]  d;
  reg [31:0]  st;
  reg [1:0]   r;
  receive_fifo_status uut (.*);
  host_bus_model hb (.*);
  // 250 MHz clock
  always #2 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // whole status image from the queue model
  function [31:0] img(input [9:0] cap);
    reg tok;
    begin
      tok = (q.size() > 0) ? tg[0] : 1'b0;
      img = {tok ? q[0][8:0] + 9'h001 : 9'h000, cap, 10'(q.size()),
             tok ? q[0][23] : 1'b0, tok, q.size() == 0};
    end
  endfunction
  // open a block of n quadlets, then load its random data
  task load_block(input [8:0] n, input lastBit);
    integer k;
    begin
      hb.wr(8'h48, {8'h00, lastBit, 14'h0000, n}, r);
      q.push_back({8'h00, lastBit | !split, 14'h0000, n});
      tg.push_back(1'b1);
      for (k = 0; k < n; k = k + 1) begin
        d = $random(seed);
        hb.wr(8'h44, d, r);
        q.push_back(d);
        tg.push_back(1'b0);
      end
    end
  endtask
  // host reads status, then bursts the token and its block
  task read_block(input [9:0] cap);
    integer k, n;
    begin
      hb.rd(8'h3c, st, r);
      chk(st, img(cap));
      n = tg[0] ? q[0][8:0] + 1 : 0;
      for (k = 0; k < n; k = k + 1) begin
        hb.rd(8'hc0, d, r);
        chk(d, q.pop_front());
        tg.delete(0);
      end
    end
  endtask
  task wrap_up;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog, far beyond a few hundred cycles of traffic
  initial begin
    #40000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    hb.rd(8'h3c, d, r);
    chk(d, img(10'd512));
    hb.wr(8'h3c, 32'hffffffff, r);
    chk(r, 32'h0);
    hb.wr(8'h10, 32'h1, r);
    chk(r, 32'h2);
    hb.rd(8'h3c, d, r);
    chk(d, img(10'd512));
    hb.rd(8'h10, d, r);
    chk({d[29:0], r}, 32'h2);
    // transmit sizes 16 and 32 leave 464 quadlets
    hb.wr(8'h40, 32'h02001000, r);
    // splitting off: the block ends the packet even with last clear
    load_block(9'd5, 1'b0);
    hb.rd(8'h3c, d, r);
    chk(d, img(10'd464));
    read_block(10'd464);
    // splitting on, flush off: two blocks, host loops until last
    split = 1'b1;
    hb.wr(8'h40, 32'h02001001, r);
    load_block(9'd2, 1'b0);
    load_block(9'd1, 1'b1);
    i = 0;
    do begin
      read_block(10'd464);
      i = i + 1;
    end while (!st[2] && i < 4);
    chk(i, 32'h2);
    // flush-bad on forces single blocks again
    split = 1'b0;
    hb.wr(8'h40, 32'h02001003, r);
    load_block(9'd1, 1'b0);
    read_block(10'd464);
    hb.rd(8'h3c, d, r);
    chk(d, img(10'd464));
    wrap_up;
  end
endmodule

// *** tb/rx_status_props.sv ***
`timescale 1ns/1ps
// bus handshake and status image checks
module rx_status_props (
  input wire        clk,
  input wire        rst_n,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  reg  [7:0] rdAddr;
  wire       stat;
  assign stat = s_axi_rvalid && rdAddr == 8'h3c;
  // address of the read in flight
  always @(posedge clk or negedge rst_n)
    if (!rst_n) rdAddr <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("rdata changed early");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_empty_count: assert property (stat |-> s_axi_rdata[0] == (s_axi_rdata[12:3] == 10'h000))
    else $error("empty flag and count disagree");
  a_next_token: assert property (stat && s_axi_rdata[1] |-> s_axi_rdata[31:23] != 9'h000)
    else $error("next block count zero");
  a_next_fits: assert property (stat && s_axi_rdata[1] |-> s_axi_rdata[31:23] <= s_axi_rdata[12:3])
    else $error("next block above total");
  a_bad_addr: assert property (s_axi_rvalid && rdAddr == 8'h10 |-> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  a_last_token: assert property (stat && !s_axi_rdata[1] |-> !s_axi_rdata[2])
    else $error("block-last set without token");
  cover property (stat && s_axi_rdata[1]);
  cover property (stat && !s_axi_rdata[0]);
  cover property (stat && s_axi_rdata[0]);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind receive_fifo_status rx_status_props chk (.*);
